// ==== otpwp_params.svh ====
`ifndef OTPWP_PARAMS_SVH
`define OTPWP_PARAMS_SVH

// ****************************************
// widths
// ****************************************
`define OTPWP_ADDR_W 18
`define OTPWP_DATA_W 16
`define OTPWP_TMR_W 10
`define OTPWP_RETRY_W 4

// ****************************************
// clock and pin timing
// ****************************************
`define OTPWP_CLK_MHZ 10
`define OTPWP_PULSE_NS 50000
`define OTPWP_SETUP_NS 2000
`define OTPWP_DATA_VALID_NS 150
`define OTPWP_FLOAT_NS 130
`define OTPWP_PULSE_CYC ((`OTPWP_PULSE_NS * `OTPWP_CLK_MHZ) / 1000)
`define OTPWP_SETUP_CYC ((`OTPWP_SETUP_NS * `OTPWP_CLK_MHZ + 999) / 1000)
`define OTPWP_VALID_CYC ((`OTPWP_DATA_VALID_NS * `OTPWP_CLK_MHZ + 999) / 1000)
`define OTPWP_FLOAT_CYC ((`OTPWP_FLOAT_NS * `OTPWP_CLK_MHZ + 999) / 1000)

// ****************************************
// algorithm limits and pin positions
// ****************************************
`define OTPWP_RETRY_MAX 10
`define OTPWP_ID_SEL_BIT 0

`endif

// ==== otpwp_pkg.sv ====
`include "otpwp_params.svh"

package otpwp_pkg;

  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_SUPPLY = 10'h002,
    ST_PSETUP = 10'h004,
    ST_PULSE  = 10'h008,
    ST_PHOLD  = 10'h010,
    ST_VREAD  = 10'h020,
    ST_VFLOAT = 10'h040,
    ST_IDREAD = 10'h080,
    ST_DONE   = 10'h100,
    ST_SPARE  = 10'h200
  } otpwp_state_type;

  typedef enum logic [3:0] {
    PH_INIT  = 4'h1,
    PH_RETRY = 4'h2,
    PH_FINAL = 4'h4,
    PH_IDENT = 4'h8
  } otpwp_phase_type;

  typedef struct packed {
    logic [`OTPWP_ADDR_W-1:0] addr;
    logic [`OTPWP_DATA_W-1:0] data_lines;
    logic data_oe;
    logic ce_n;
    logic oe_n;
    logic id_entry_address_pin;
    logic vcc_prog;
    logic vpp_prog;
  } otpwp_pins_type;

  typedef struct packed {
    logic busy;
    logic pass;
    logic fail;
    logic [`OTPWP_ADDR_W-1:0] fail_addr;
    logic [`OTPWP_DATA_W-1:0] id_word;
  } otpwp_status_type;

endpackage

// ==== otpwp_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "otpwp_params.svh"

module otpwp_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic load,
  input wire logic [`OTPWP_TMR_W-1:0] load_value,
  output logic expired
);

  logic [`OTPWP_TMR_W-1:0] count;
  logic running;

  assign expired = running && (count == `OTPWP_TMR_W'(1));

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= '0;
      running <= 1'b0;
    end else if (load) begin
      count <= load_value;
      running <= 1'b1;
    end else if (running) begin
      count <= count - `OTPWP_TMR_W'(1);
      running <= !expired;
    end
  end

endmodule
`default_nettype wire

// ==== otpwp_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "otpwp_params.svh"

// Function
// - program pulse on chip enable is 50 us
// - first address, raised supplies before pulsing
// - one unverified pulse per address first
// - then verify loop per address
// - failing word gets single pulses, verify each
// - ten retries failing stops, part failed
// - verified word advances address until last
// - lower supplies, reread all, declare result
// - wait data valid delay, then float delay
// - id entry pin high, id select chooses word

module otpwp_ctrl
  import otpwp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // user command
  input wire logic start,
  input wire logic mode_ident,
  input wire logic ident_device_word,
  input wire logic [`OTPWP_ADDR_W-1:0] first_addr,
  input wire logic [`OTPWP_ADDR_W-1:0] last_addr,
  // source image, looked up at pins.addr
  input wire logic [`OTPWP_DATA_W-1:0] src_data,
  // memory pins
  input wire logic [`OTPWP_DATA_W-1:0] data_lines_in,
  output otpwp_pins_type pins,
  // result
  output otpwp_status_type status,
  output logic done
);

  // ****************************************
  // sequencer state
  // ****************************************
  otpwp_state_type state;
  otpwp_state_type next_state;
  otpwp_phase_type phase;
  logic [`OTPWP_ADDR_W-1:0] addr;
  logic [`OTPWP_ADDR_W-1:0] last;
  logic [`OTPWP_RETRY_W-1:0] retry;
  logic id_word_select;
  logic final_bad;
  logic match;
  logic at_last;
  logic expired;
  logic tmr_load;
  logic [`OTPWP_TMR_W-1:0] tmr_value;
  logic match_q;
  logic in_run;
  logic raise_supply;

  assign match = (data_lines_in == src_data);
  assign at_last = (addr == last);
  // supplies and id voltage drop as the run ends, not a cycle later
  assign in_run = status.busy && state != ST_DONE && next_state != ST_DONE;
  assign raise_supply = in_run && (phase == PH_INIT || phase == PH_RETRY);
  assign tmr_load = (next_state != state);

  otpwp_timer u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_value(tmr_value),
    .expired(expired)
  );

  // ****************************************
  // wait length of each state
  // ****************************************
  always_comb begin
    case (next_state)
      // one extra cycle: data follows the new address by one cycle
      ST_PSETUP: tmr_value = `OTPWP_TMR_W'(`OTPWP_SETUP_CYC + 1);
      ST_PULSE: tmr_value = `OTPWP_TMR_W'(`OTPWP_PULSE_CYC);
      ST_VREAD: tmr_value = `OTPWP_TMR_W'(`OTPWP_VALID_CYC);
      ST_IDREAD: tmr_value = `OTPWP_TMR_W'(`OTPWP_VALID_CYC);
      ST_VFLOAT: tmr_value = `OTPWP_TMR_W'(`OTPWP_FLOAT_CYC);
      default: tmr_value = `OTPWP_TMR_W'(`OTPWP_SETUP_CYC);
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_SUPPLY;
        end
      end
      ST_SUPPLY: begin
        // supplies and address settle before anything is strobed
        if (expired) begin
          case (phase)
            PH_INIT: next_state = ST_PSETUP;
            PH_IDENT: next_state = ST_IDREAD;
            default: next_state = ST_VREAD;
          endcase
        end
      end
      ST_PSETUP: begin
        if (expired) begin
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (expired) begin
          next_state = ST_PHOLD;
        end
      end
      ST_PHOLD: begin
        if (expired) begin
          if (phase == PH_INIT && !at_last) begin
            next_state = ST_PSETUP;
          end else begin
            next_state = ST_VREAD;
          end
        end
      end
      ST_VREAD: begin
        if (expired) begin
          next_state = ST_VFLOAT;
        end
      end
      ST_IDREAD: begin
        if (expired) begin
          next_state = ST_VFLOAT;
        end
      end
      ST_VFLOAT: begin
        if (expired) begin
          case (phase)
            PH_RETRY: begin
              if (status.fail) begin
                next_state = ST_DONE;
              end else if (!match_q) begin
                next_state = ST_PSETUP;
              end else if (at_last) begin
                next_state = ST_SUPPLY;
              end else begin
                next_state = ST_VREAD;
              end
            end
            PH_FINAL: next_state = at_last ? ST_DONE : ST_VREAD;
            default: next_state = ST_DONE;
          endcase
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // sampled compare result
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      match_q <= 1'b0;
    end else if (state == ST_VREAD && expired) begin
      match_q <= match;
    end
  end

  // ****************************************
  // phase, address and retry count
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase <= PH_INIT;
      addr <= '0;
      last <= '0;
      retry <= '0;
      id_word_select <= 1'b0;
    end else if (state == ST_IDLE && start) begin
      phase <= mode_ident ? PH_IDENT : PH_INIT;
      addr <= mode_ident ? '0 : first_addr;
      last <= last_addr;
      retry <= '0;
      id_word_select <= ident_device_word;
    end else if (state == ST_PHOLD && expired) begin
      if (phase == PH_INIT) begin
        // initial pass ends at the last word, then verify from the top
        if (at_last) begin
          phase <= PH_RETRY;
          addr <= first_addr;
        end else begin
          addr <= addr + `OTPWP_ADDR_W'(1);
        end
      end else begin
        retry <= retry + `OTPWP_RETRY_W'(1);
      end
    end else if (state == ST_VFLOAT && expired) begin
      if (phase == PH_RETRY && match_q) begin
        retry <= '0;
        if (at_last) begin
          phase <= PH_FINAL;
          addr <= first_addr;
        end else begin
          addr <= addr + `OTPWP_ADDR_W'(1);
        end
      end else if (phase == PH_FINAL && !at_last) begin
        addr <= addr + `OTPWP_ADDR_W'(1);
      end
    end
  end

  // ****************************************
  // result
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status <= '0;
      final_bad <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= (state == ST_DONE);
      if (state == ST_IDLE && start) begin
        status <= '0;
        status.busy <= 1'b1;
        final_bad <= 1'b0;
      end else if (state == ST_VREAD && expired) begin
        if (phase == PH_RETRY && !match &&
            retry == `OTPWP_RETRY_W'(`OTPWP_RETRY_MAX)) begin
          // the whole part is rejected, not only this word
          status.fail <= 1'b1;
          status.fail_addr <= addr;
        end
        if (phase == PH_FINAL && !match && !final_bad) begin
          final_bad <= 1'b1;
          status.fail_addr <= addr;
        end
      end else if (state == ST_IDREAD && expired) begin
        status.id_word <= data_lines_in;
      end else if (state == ST_DONE) begin
        status.busy <= 1'b0;
        if (phase == PH_FINAL) begin
          status.pass <= !final_bad;
          status.fail <= final_bad;
        end else if (phase == PH_IDENT) begin
          status.pass <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // pin drive, registered; strobes and data enable decoded from the next state
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pins <= '0;
      pins.ce_n <= 1'b1;
      pins.oe_n <= 1'b1;
    end else begin
      pins.addr <= addr;
      pins.ce_n <= !(next_state == ST_PULSE ||
                     next_state == ST_IDREAD);
      pins.oe_n <= !(next_state == ST_VREAD ||
                     next_state == ST_IDREAD);
      pins.data_oe <= (next_state == ST_PSETUP ||
                       next_state == ST_PULSE ||
                       next_state == ST_PHOLD);
      // src_data follows pins.addr, which lands one cycle into setup
      if (state == ST_PSETUP) begin
        pins.data_lines <= src_data;
      end
      pins.vcc_prog <= raise_supply;
      pins.vpp_prog <= raise_supply;
      pins.id_entry_address_pin <= in_run && phase == PH_IDENT;
      if (status.busy && phase == PH_IDENT) begin
        pins.addr <= '0;
        pins.addr[`OTPWP_ID_SEL_BIT] <= id_word_select;
      end
    end
  end

endmodule
`default_nettype wire

// ==== otpwp_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "otpwp_params.svh"

module otpwp_properties
  import otpwp_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // user command
  input wire logic start,
  input wire logic mode_ident,
  input wire logic ident_device_word,
  input wire logic [`OTPWP_ADDR_W-1:0] first_addr,
  input wire logic [`OTPWP_ADDR_W-1:0] last_addr,
  input wire logic [`OTPWP_DATA_W-1:0] src_data,
  // memory pins
  input wire logic [`OTPWP_DATA_W-1:0] data_lines_in,
  input wire otpwp_pins_type pins,
  // result
  input wire otpwp_status_type status,
  input wire logic done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // pulse length counter
  // ****************************************
  logic [15:0] low_cnt;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || pins.ce_n) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  sequence s_id_start;
    start && !status.busy && mode_ident;
  endsequence

  sequence s_read_open;
    $fell(pins.oe_n);
  endsequence

  // ****************************************
  // properties
  // ****************************************
  // 475 to 525 cycles at 100 ns
  AST_PULSE_WIDTH: assert property ($rose(pins.ce_n) && pins.vpp_prog |->
    low_cnt >= 16'h01DB && low_cnt <= 16'h020D)
    else $error("program pulse width out of range");
  AST_SUPPLY_UP: assert property ($fell(pins.ce_n) && pins.oe_n |->
    pins.vcc_prog && pins.vpp_prog)
    else $error("pulse without raised supplies");
  AST_DRIVE_PROG: assert property (!pins.ce_n && pins.oe_n |->
    pins.data_oe)
    else $error("data not driven in pulse");
  AST_RELEASE_READ: assert property (!pins.oe_n |-> !pins.data_oe)
    else $error("data driven while reading");
  AST_VERIFY_CE_HIGH: assert property (!pins.oe_n && pins.vpp_prog |->
    pins.ce_n)
    else $error("verify read with chip enable low");
  AST_ID_SELECT: assert property (s_id_start |=> ##1
    pins.id_entry_address_pin && pins.addr[17:1] == 17'h00000 &&
    pins.addr[0] == $past(ident_device_word, 2))
    else $error("id entry pins wrong");
  AST_VALID_WAIT: assert property (s_read_open |-> (!pins.oe_n) [*2])
    else $error("read sampled too early");
  AST_FLOAT_WAIT: assert property ($rose(pins.oe_n) |->
    (pins.ce_n && !pins.data_oe) [*2])
    else $error("float delay not kept");
  AST_DONE_LOW: assert property (done |->
    !pins.vcc_prog && !pins.vpp_prog && pins.ce_n)
    else $error("supplies raised at end");
endmodule

bind otpwp_ctrl otpwp_properties u_props (.clk_sys, .sys_rst, .start,
  .mode_ident, .ident_device_word, .first_addr, .last_addr, .src_data,
  .data_lines_in, .pins, .status, .done);

`default_nettype wire

// ==== otpwp_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module otpwp_mem_model
  import otpwp_pkg::*;
#(
  // arbitrary id values, upper byte zero
  parameter logic [15:0] MAKER_CODE = 16'h005A,
  parameter logic [15:0] DEVICE_CODE = 16'h00C3
)
(
  // programmer pins
  input wire otpwp_pins_type pins,
  // test control
  input wire logic wipe,
  input wire logic [7:0] need0,
  input wire logic [7:0] need1,
  // resolved data lines
  output logic [15:0] data_lines_in
);
  logic [15:0] mem [0:1];
  logic [7:0] hits [0:1];

  // a word takes only once its pulse count reaches need0 or need1
  always @(posedge pins.ce_n or posedge wipe) begin
    if (wipe) begin
      mem[0] = 16'hFFFF;
      mem[1] = 16'hFFFF;
      hits[0] = 8'h00;
      hits[1] = 8'h00;
    end else if (pins.oe_n && pins.data_oe && pins.vpp_prog) begin
      hits[pins.addr[0]] = hits[pins.addr[0]] + 8'h01;
      if (hits[pins.addr[0]] >= (pins.addr[0] ? need1 : need0)) begin
        mem[pins.addr[0]] = mem[pins.addr[0]] & pins.data_lines;
      end
    end
  end

  // no pull on the lines: released lines show the inverse word
  always_comb begin
    if (pins.data_oe) begin
      data_lines_in = pins.data_lines;
    end else if (!pins.oe_n && pins.id_entry_address_pin) begin
      data_lines_in = pins.addr[0] ? DEVICE_CODE : MAKER_CODE;
    end else if (!pins.oe_n) begin
      data_lines_in = mem[pins.addr[0]];
    end else begin
      data_lines_in = ~mem[pins.addr[0]];
    end
  end
endmodule

`default_nettype wire

// ==== otp_word_program_verify_id_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "otpwp_params.svh"

module otp_word_program_verify_id_test import otpwp_pkg::*;;
  // arbitrary id values, upper byte zero
  localparam logic [15:0] MAKER_WORD = 16'h005A;
  localparam logic [15:0] DEVICE_WORD = 16'h00C3;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic mode_ident = 1'b0;
  logic ident_device_word = 1'b0;
  logic wipe = 1'b0;
  logic [17:0] first_addr = 18'h00000;
  logic [17:0] last_addr = 18'h00001;
  logic [7:0] need0 = 8'h01;
  logic [7:0] need1 = 8'h01;
  logic [15:0] data_lines_in;
  logic [15:0] image [0:1] = '{16'hA5C3, 16'h3C0F};
  otpwp_pins_type pins;
  otpwp_status_type status;
  logic done;
  wire logic [15:0] src_data = image[pins.addr[0]];
  int fails = 0;
  int n_compared = 0;
  int pulses = 0;
  int reads = 0;

  always #50 clk_sys = ~clk_sys;
  always @(negedge pins.ce_n) if (pins.vpp_prog) pulses++;
  always @(negedge pins.oe_n)
    if (!pins.vcc_prog && !pins.id_entry_address_pin) reads++;

  otpwp_ctrl dut (.clk_sys, .sys_rst, .start, .mode_ident,
    .ident_device_word, .first_addr, .last_addr, .src_data,
    .data_lines_in, .pins, .status, .done);
  otpwp_mem_model #(.MAKER_CODE(MAKER_WORD), .DEVICE_CODE(DEVICE_WORD))
    model (.pins, .wipe, .need0, .need1, .data_lines_in);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic run(input logic id, input logic sel);
    int n;
    n = 0;
    pulses = 0;
    reads = 0;
    @(posedge clk_sys);
    wipe <= 1'b0;
    mode_ident <= id;
    ident_device_word <= sel;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      fails++;
      report_and_stop;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_ident;
    run(1'b1, 1'b0);
    check(status.id_word, MAKER_WORD);
    run(1'b1, 1'b1);
    check(status.id_word, DEVICE_WORD);
    check(status.pass, 1'b1);
    $display("ident test over");
  endtask

  task automatic t_prog(input logic [7:0] n0, input logic [7:0] n1,
    input logic [31:0] want_pulses, input logic want_fail);
    need0 <= n0;
    need1 <= n1;
    wipe <= 1'b1;
    run(1'b0, 1'b0);
    check(pulses, want_pulses);
    check(status.fail, want_fail);
    check(status.pass, !want_fail);
    check(status.busy, 1'b0);
    if (want_fail) check(status.fail_addr, 18'h00001);
    else check(reads, 32'h2);
    $display("program test over");
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_ident;
    t_prog(8'h01, 8'h01, 32'h2, 1'b0);
    t_prog(8'h04, 8'h04, 32'h8, 1'b0);
    t_prog(8'h01, 8'h63, 32'hC, 1'b1);
    report_and_stop;
  end

  initial begin
    #3000000;
    fails++;
    report_and_stop;
  end
endmodule

`default_nettype wire
